/* design/csup_supervisor.sv */
// Purpose: stop supervisor for backward stability and working range limits
// Assumes: measurements and motion commands synchronous to hclk
// Notes:   limit record mirrored to a battery-backed memory, read latency 1
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

module csup_supervisor
    import csup_pkg::*;
#(
    parameter int W        = 16,            // measurement width
    parameter int HOLD_CYC = CSUP_HOLD_CYC  // stop hold time in cycles
) (
    input  wire logic          hclk,          // controller clock
    input  wire logic          hresetn,       // async reset, low active
    input  wire logic          ce,            // clock enable, freezes all
    input  wire logic          hsel,          // slave select
    input  wire logic [31:0]   haddr,         // byte address
    input  wire logic [1:0]    htrans,        // transfer type
    input  wire logic          hwrite,        // write transfer
    input  wire logic [2:0]    hsize,         // transfer size
    input  wire logic [31:0]   hwdata,        // write data
    input  wire logic          hready,        // bus ready in
    output logic               hreadyout,     // slave ready
    output logic               hresp,         // always okay
    output logic [31:0]        hrdata,        // read data
    input  wire logic [W-1:0]  height,        // lifting height
    input  wire logic [W-1:0]  boom_angle,    // boom elevation angle
    input  wire logic [W-1:0]  radius,        // load radius
    input  wire logic [W-1:0]  swing_angle,   // swing angle, rises to right
    input  wire logic [8:0]    motion_cmd,    // commanded motions
    input  wire logic          override_sw,   // emergency override switch
    input  wire logic          swing_cancel,  // swing stop cancel
    input  wire logic [15:0]   shutdown_min,  // minutes since shutdown
    input  wire logic [15:0]   bk_rdata,      // backup memory read data
    output logic [6:0]         stop_out,      // stop valves, non-swing
    output logic [1:0]         swing_pv_stop, // swing valve stop, right/left
    output logic [15:0]        warn_code,     // displayed warning code
    output logic               bk_re,         // backup read strobe
    output logic               bk_we,         // backup write strobe
    output logic [2:0]         bk_addr,       // backup word address
    output logic [15:0]        bk_wdata       // backup write data
);
    localparam int CW = $clog2(HOLD_CYC + 1);
    localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYC);
    localparam int NCH = CSUP_NLIM + 1;    // channel 6 is backward stability

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [W-1:0]   lim [CSUP_NLIM], next_lim [CSUP_NLIM]; // taught limit values
    logic [5:0]     lim_en, next_lim_en;   // limit enables
    logic           restop, next_restop;   // re-stop setting
    logic           valve, next_valve;     // swing valve fitted
    logic [W-1:0]   bs_lim, next_bs_lim;   // backward stability angle
    logic [W-1:0]   hyst, next_hyst;       // hysteresis band
    logic [NCH-1:0] over, next_over;       // over-limit flags
    logic [CW-1:0]  hold [NCH], next_hold [NCH]; // stop hold counters
    logic [8:0]     stop9, next_stop9;     // stopped motions
    logic [15:0]    next_code;             // next warning code
    logic           wr_pend, next_wr_pend; // write data phase pending
    logic           rd_pend, next_rd_pend; // read data phase pending
    logic [7:0]     bus_addr, next_bus_addr;
    logic           next_hreadyout;
    logic [31:0]    next_hrdata;
    csup_state_type state, next_state;     // record sequencer
    logic [2:0]     idx, next_idx;         // record word index
    logic [1:0]     phase, next_phase;     // load phase
    logic           store_pend, next_store_pend;
    logic           next_bk_re, next_bk_we;
    logic [2:0]     next_bk_addr;
    logic [15:0]    next_bk_wdata;
    logic [W-1:0]   meas [CSUP_NLIM];      // position seen by each limit

    assign meas[0] = height;
    assign meas[1] = boom_angle;
    assign meas[2] = boom_angle;
    assign meas[3] = radius;
    assign meas[4] = swing_angle;
    assign meas[5] = swing_angle;

    // ----------------------------------------------------------------
    // limit supervision
    // ----------------------------------------------------------------
    // compares, cancels, hold timers and the warning display
    always_comb begin
        logic [W:0] lo_band;
        logic [W:0] hi_band;
        logic       want;
        logic       cancel;
        logic       act;
        lo_band    = '0;
        hi_band    = '0;
        want       = 1'b0;
        cancel     = 1'b0;
        act        = 1'b0;
        next_stop9 = '0;
        next_code  = CSUP_W_NONE;
        for (int i = CSUP_NLIM - 1; i >= 0; i--) begin
            hi_band = {1'b0, meas[i]} + {1'b0, hyst};
            lo_band = {1'b0, lim[i]} + {1'b0, hyst};
            if (CSUP_LOWER_LIM[i]) begin
                next_over[i] = over[i] ? ({1'b0, meas[i]} <= lo_band)
                                       : (meas[i] <= lim[i]);
            end else begin
                next_over[i] = over[i] ? (hi_band >= {1'b0, lim[i]})
                                       : (meas[i] >= lim[i]);
            end
            want = lim_en[i] & over[i] & (|(motion_cmd & CSUP_MASK_LIM[i]));
            cancel = override_sw;
            if (i >= 4) begin
                cancel = swing_cancel | (override_sw & ~restop);
                want = want & valve;
            end
            act = want & ~cancel;
            next_hold[i] = (cancel || hold[i] == '0) ? '0 : hold[i] - 1'b1;
            if (act) begin
                next_hold[i] = HOLD_LOAD;
            end
            if (next_hold[i] != '0) begin
                next_stop9 = next_stop9 | CSUP_MASK_LIM[i];
            end
            if (next_hold[i] != '0 || (i >= 4 && want)) begin
                next_code = CSUP_W_LIM[i];
            end
        end
        hi_band = {1'b0, boom_angle} + {1'b0, hyst};
        next_over[6] = over[6] ? (hi_band > {1'b0, bs_lim}) : (boom_angle > bs_lim);
        act = over[6] & (|(motion_cmd & CSUP_MASK_BS));
        next_hold[6] = (hold[6] == '0) ? '0 : hold[6] - 1'b1;
        if (act) begin
            next_hold[6] = HOLD_LOAD;
        end
        if (next_hold[6] != '0) begin
            next_stop9 = next_stop9 | CSUP_MASK_BS;
            next_code = CSUP_W_BS_STOP;
        end else if (over[6]) begin
            next_code = CSUP_W_BS_OVER;
        end
    end

    // registers the supervision state and the stop outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            over          <= '0;
            stop9         <= '0;
            stop_out      <= '0;
            swing_pv_stop <= '0;
            warn_code     <= CSUP_W_NONE;
            hold          <= '{default: '0};
        end else if (ce) begin
            over          <= next_over;
            stop9         <= next_stop9;
            stop_out      <= next_stop9[6:0];
            swing_pv_stop <= next_stop9[8:7];
            warn_code     <= next_code;
            hold          <= next_hold;
        end
    end

    // ----------------------------------------------------------------
    // bus slave, registers and limit record
    // ----------------------------------------------------------------
    // bus phases, register writes, teaching and backup sequencing
    always_comb begin
        logic changed;
        changed         = 1'b0;
        next_lim        = lim;
        next_lim_en     = lim_en;
        next_restop     = restop;
        next_valve      = valve;
        next_bs_lim     = bs_lim;
        next_hyst       = hyst;
        next_state      = state;
        next_idx        = idx;
        next_phase      = phase;
        next_bk_re      = 1'b0;
        next_bk_we      = 1'b0;
        next_bk_addr    = bk_addr;
        next_bk_wdata   = bk_wdata;
        next_hrdata     = hrdata;
        next_hreadyout  = 1'b1;
        next_rd_pend    = 1'b0;
        next_wr_pend    = 1'b0;
        next_bus_addr   = bus_addr;
        // address phase: reads take one wait state
        if (hsel && hready && htrans[1]) begin
            next_bus_addr  = haddr[7:0];
            next_wr_pend   = hwrite;
            next_rd_pend   = ~hwrite;
            next_hreadyout = hwrite;
        end
        // read data taken after any earlier write has landed
        if (rd_pend) begin
            next_hrdata = 32'h00000000; // unmapped reads 0
            if (bus_addr == CSUP_OFS_CTRL) begin
                next_hrdata = {24'h000000, valve, restop, lim_en};
            end else if (bus_addr == CSUP_OFS_BSLIM) begin
                next_hrdata = 32'(bs_lim);
            end else if (bus_addr == CSUP_OFS_HYST) begin
                next_hrdata = 32'(hyst);
            end else if (bus_addr == CSUP_OFS_STATUS) begin
                next_hrdata = {stop9, over, warn_code};
            end
            for (int i = 0; i < CSUP_NLIM; i++) begin
                if (bus_addr == CSUP_OFS_LIMIT0 + 8'(i) * CSUP_OFS_STEP) begin
                    next_hrdata = 32'(lim[i]);
                end
            end
        end
        // write data phase
        if (wr_pend) begin
            if (bus_addr == CSUP_OFS_CTRL) begin
                next_lim_en = hwdata[CSUP_EN_LSB +: CSUP_NLIM];
                next_restop = hwdata[CSUP_RESTOP_BIT];
                next_valve  = hwdata[CSUP_VALVE_BIT];
                for (int i = 0; i < CSUP_NLIM; i++) begin
                    if (hwdata[CSUP_TEACH_LSB + i]) begin
                        next_lim[i] = meas[i];
                    end
                end
            end else if (bus_addr == CSUP_OFS_BSLIM) begin
                next_bs_lim = hwdata[W-1:0];
            end else if (bus_addr == CSUP_OFS_HYST) begin
                next_hyst = hwdata[W-1:0];
            end
            for (int i = 0; i < CSUP_NLIM; i++) begin
                if (bus_addr == CSUP_OFS_LIMIT0 + 8'(i) * CSUP_OFS_STEP) begin
                    next_lim[i] = hwdata[W-1:0];
                end
            end
        end
        case (state)
            ST_BOOT: begin
                // reuse record only after a short outage
                next_idx   = 3'h0;
                next_phase = 2'h0;
                next_state = (shutdown_min <= CSUP_RETAIN_MIN) ? ST_LOAD : ST_IDLE;
            end
            ST_LOAD: begin
                if (phase == 2'h0) begin
                    next_bk_re   = 1'b1;
                    next_bk_addr = idx;
                    next_phase   = 2'h1;
                end else if (phase == 2'h1) begin
                    next_phase = 2'h2;
                end else begin
                    if (idx == CSUP_BK_LAST) begin
                        next_lim_en = bk_rdata[5:0];
                        next_state  = ST_IDLE;
                    end else begin
                        next_lim[idx] = bk_rdata[W-1:0];
                    end
                    next_idx   = idx + 3'h1;
                    next_phase = 2'h0;
                end
            end
            ST_IDLE: begin
                next_idx = 3'h0;
                if (store_pend) begin
                    next_state = ST_STORE;
                end
            end
            default: begin
                next_bk_we    = 1'b1;
                next_bk_addr  = idx;
                next_bk_wdata = (idx == CSUP_BK_LAST) ? {10'h000, lim_en}
                                                      : 16'(lim[idx]);
                next_idx      = idx + 3'h1;
                if (idx == CSUP_BK_LAST) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
        // any limit or enable change outside ST_LOAD asks for a rewrite
        changed = (next_lim_en != lim_en);
        for (int i = 0; i < CSUP_NLIM; i++) begin
            changed = changed | (next_lim[i] != lim[i]);
        end
        next_store_pend = (store_pend & ~(state == ST_IDLE)) |
                          (changed & (state != ST_LOAD));
    end

    // registers bus, register file and record sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lim        <= '{default: W'(CSUP_LIMIT_RST)};
            lim_en     <= '0;
            restop     <= 1'b0;
            valve      <= 1'b0;
            bs_lim     <= CSUP_BSLIM_RST;
            hyst       <= CSUP_HYST_RST;
            state      <= ST_BOOT;
            idx        <= 3'h0;
            phase      <= 2'h0;
            store_pend <= 1'b0;
            bk_re      <= 1'b0;
            bk_we      <= 1'b0;
            bk_addr    <= 3'h0;
            bk_wdata   <= 16'h0000;
            hrdata     <= 32'h00000000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            rd_pend    <= 1'b0;
            wr_pend    <= 1'b0;
            bus_addr   <= 8'h00;
        end else if (ce) begin
            lim        <= next_lim;
            lim_en     <= next_lim_en;
            restop     <= next_restop;
            valve      <= next_valve;
            bs_lim     <= next_bs_lim;
            hyst       <= next_hyst;
            state      <= next_state;
            idx        <= next_idx;
            phase      <= next_phase;
            store_pend <= next_store_pend;
            bk_re      <= next_bk_re;
            bk_we      <= next_bk_we;
            bk_addr    <= next_bk_addr;
            bk_wdata   <= next_bk_wdata;
            hrdata     <= next_hrdata;
            hreadyout  <= next_hreadyout;
            rd_pend    <= next_rd_pend;
            wr_pend    <= next_wr_pend;
            bus_addr   <= next_bus_addr;
        end
    end
endmodule

/* pkg/csup_pkg.sv */
// Purpose: shared constants of the crane motion stop supervisor
// Assumes: 32-bit AHB-Lite register bus, 10 MHz controller clock
// Notes:   warning codes are held as hex digits of the displayed number
package csup_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CSUP_OFS_CTRL   = 8'h00;
    localparam logic [7:0] CSUP_OFS_BSLIM  = 8'h04;
    localparam logic [7:0] CSUP_OFS_HYST   = 8'h08;
    localparam logic [7:0] CSUP_OFS_STATUS = 8'h0C;
    localparam logic [7:0] CSUP_OFS_LIMIT0 = 8'h10; // six limits, one word each
    localparam logic [7:0] CSUP_OFS_STEP   = 8'h04;
    // control fields
    localparam int CSUP_EN_LSB     = 0;  // six limit enables
    localparam int CSUP_RESTOP_BIT = 6;  // re-stop setting
    localparam int CSUP_VALVE_BIT  = 7;  // swing proportional valve fitted
    localparam int CSUP_TEACH_LSB  = 8;  // six teach strobes, self clearing
    // status fields
    localparam int CSUP_ST_OVER_LSB = 16; // seven over-limit flags
    localparam int CSUP_ST_STOP_LSB = 23; // nine stopped motions
    // reset values
    localparam logic [15:0] CSUP_BSLIM_RST = 16'hFFFF;
    localparam logic [15:0] CSUP_HYST_RST  = 16'h0010;
    localparam logic [15:0] CSUP_LIMIT_RST = 16'h0000;
    // ----------------------------------------------------------------
    // motions: 0 boom ext, 1 boom ret, 2 elev raise, 3 elev lower,
    // 4 jib ext, 5 jib tilt raise, 6 jib tilt lower, 7 right, 8 left
    // ----------------------------------------------------------------
    localparam int CSUP_NMOT = 9;
    localparam int CSUP_NLIM = 6;   // height, upper, lower, radius, right, left
    localparam logic [8:0] CSUP_MASK_BS = 9'h006;
    localparam logic [8:0] CSUP_MASK_LIM [CSUP_NLIM] = '{
        9'h035, 9'h004, 9'h008, 9'h059, 9'h080, 9'h100};
    // limits that trip when the measured value falls to or below them
    localparam logic [5:0] CSUP_LOWER_LIM = 6'h24;
    // ----------------------------------------------------------------
    // warning codes
    // ----------------------------------------------------------------
    localparam logic [15:0] CSUP_W_BS_OVER = 16'h0012;
    localparam logic [15:0] CSUP_W_BS_STOP = 16'h0025;
    localparam logic [15:0] CSUP_W_LIM [CSUP_NLIM] = '{
        16'h0028, 16'h0026, 16'h0027, 16'h0029, 16'h0042, 16'h0043};
    localparam logic [15:0] CSUP_W_NONE = 16'h0000;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CSUP_CLK_HZ      = 10_000_000;
    localparam int CSUP_HOLD_MS     = 2000;
    localparam int CSUP_HOLD_CYC    = CSUP_HOLD_MS * (CSUP_CLK_HZ / 1000);
    localparam logic [15:0] CSUP_RETAIN_MIN = 16'h0078; // 2 hours in minutes
    localparam logic [2:0] CSUP_BK_LAST = 3'h6; // word 6 holds the enables
    // ----------------------------------------------------------------
    // record sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_BOOT, ST_LOAD, ST_IDLE, ST_STORE} csup_state_type;
endpackage

/* testbench/csup_bkmem.sv */
// Purpose: battery-backed record memory beside the stop supervisor
// Assumes: read data stands one cycle after the read strobe
// Notes:   contents outlive the supervisor's reset, as a battery keeps them
`timescale 1ns/1ps
module csup_bkmem (
    input  wire logic        hclk,     // controller clock
    input  wire logic        bk_re,    // read strobe
    input  wire logic        bk_we,    // write strobe
    input  wire logic [2:0]  bk_addr,  // word address
    input  wire logic [15:0] bk_wdata, // write data
    output logic      [15:0] bk_rdata  // read data, toggles when not read
);
    logic [15:0] mem [8]; // record words, never cleared by reset
    initial bk_rdata = 16'h5A5A;
    always @(posedge hclk) begin
        if (bk_we) mem[bk_addr] <= bk_wdata;
        bk_rdata <= bk_re ? mem[bk_addr] : ~bk_rdata;
    end
endmodule

/* testbench/csup_chk.sv */
// Purpose: concurrent checks on the stop supervisor's ports
// Assumes: one clock domain, asynchronous low active reset
// Notes:   the hold bound follows HOLD_CYC of the bound instance
`timescale 1ns/1ps
module csup_chk #(
    parameter int HOLD_CYC = 20 // stop hold time in cycles
) (
    input wire logic        hclk,          // controller clock
    input wire logic        hresetn,       // async reset, low active
    input wire logic        hreadyout,     // slave ready
    input wire logic        override_sw,   // emergency override
    input wire logic        swing_cancel,  // swing stop cancel
    input wire logic [8:0]  motion_cmd,    // commanded motions
    input wire logic [6:0]  stop_out,      // non-swing stops
    input wire logic [1:0]  swing_pv_stop, // swing valve stops
    input wire logic [15:0] warn_code,     // displayed code
    input wire logic        bk_re,         // backup read strobe
    input wire logic        bk_we,         // backup write strobe
    input wire logic [2:0]  bk_addr        // backup word address
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    int unsigned rel_cnt;      // cycles a backward stop stands unasked
    int unsigned next_rel_cnt;
    // count while retraction stop stands with no critical motion asked
    always_comb next_rel_cnt = (stop_out[1] && motion_cmd[2:1] == 2'b00) ? rel_cnt + 1 : 0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rel_cnt <= 0;
        else rel_cnt <= next_rel_cnt;
    end
    sequence s_store;
        bk_we && bk_addr == 3'h0 ##1 bk_we [*6] ##1 !bk_we;
    endsequence
    property p_bs_over;  warn_code == 16'h0012 |-> !stop_out[1]; endproperty
    property p_bs_pair;  stop_out[1] |-> stop_out[2]; endproperty
    property p_bs_code;  stop_out[1] |-> warn_code == 16'h0025; endproperty
    property p_hold_min; $rose(stop_out[1]) |-> stop_out[1] [*8]; endproperty
    property p_hold_max; rel_cnt <= HOLD_CYC + 4; endproperty
    property p_height;   warn_code == 16'h0028 |-> (stop_out & 7'h35) == 7'h35; endproperty
    property p_lower;    warn_code == 16'h0027 |-> stop_out[3]; endproperty
    property p_radius;   warn_code == 16'h0029 |-> (stop_out & 7'h59) == 7'h59; endproperty
    property p_override; override_sw [*3] |-> (stop_out & 7'h79) == 7'h00; endproperty
    property p_cancel;   swing_cancel [*3] |-> swing_pv_stop == 2'b00; endproperty
    property p_store;    $rose(bk_we) |-> s_store; endproperty
    property p_step;     bk_we && $past(bk_we) |-> bk_addr == $past(bk_addr) + 3'h1; endproperty
    property p_load;     bk_re |=> !bk_re ##1 !bk_re; endproperty
    property p_ready;    !hreadyout |=> hreadyout; endproperty
    a_bs_over: assert property (p_bs_over) else $error("over code with stop");
    a_bs_pair: assert property (p_bs_pair) else $error("backward pair split");
    a_bs_code: assert property (p_bs_code) else $error("backward stop code");
    a_hold_min: assert property (p_hold_min) else $error("hold too short");
    a_hold_max: assert property (p_hold_max) else $error("hold too long");
    a_height: assert property (p_height) else $error("height stop set");
    a_lower: assert property (p_lower) else $error("lower angle stop");
    a_radius: assert property (p_radius) else $error("radius stop set");
    a_override: assert property (p_override) else $error("override ignored");
    a_cancel: assert property (p_cancel) else $error("swing cancel ignored");
    a_store: assert property (p_store) else $error("record store shape");
    a_step: assert property (p_step) else $error("record address step");
    a_load: assert property (p_load) else $error("load strobe spacing");
    a_ready: assert property (p_ready) else $error("wait state too long");
endmodule
bind csup_supervisor csup_chk #(.HOLD_CYC(HOLD_CYC)) csup_chk_inst (.hclk, .hresetn,
    .hreadyout, .override_sw, .swing_cancel, .motion_cmd, .stop_out, .swing_pv_stop,
    .warn_code, .bk_re, .bk_we, .bk_addr);

/* testbench/tb.sv */
// Purpose: self-checking bench of the stop supervisor
// Assumes: shortened hold time, record memory model beside the design
// Notes:   expected stops and codes come from a behavioural model here
`timescale 1ns/1ps
module tb;
    import csup_pkg::*;
    localparam int HOLD = 20;              // shortened hold time
    localparam logic [15:0] BSL = 16'h8000; // backward limit used
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, override_sw = 1'b0;
    logic        swing_cancel = 1'b0, hreadyout, hresp, bk_re, bk_we;
    logic [1:0]  htrans = 2'h0, swing_pv_stop;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] height = 16'h0, boom_angle = 16'h0, radius = 16'h0, swing_angle = 16'h0;
    logic [15:0] shutdown_min = 16'h0, bk_rdata, warn_code, bk_wdata, lim [6];
    logic [8:0]  motion_cmd = 9'h0;
    logic [6:0]  stop_out;
    logic [2:0]  bk_addr;
    int          failures = 0, n_checks = 0, cfg;
    wire  [31:0] outs = {6'h0, hresp, swing_pv_stop, stop_out, warn_code}; // all results
    csup_supervisor #(.W(16), .HOLD_CYC(HOLD)) csup_supervisor_inst (.hclk, .hresetn,
        .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .height, .boom_angle, .radius,
        .swing_angle, .motion_cmd, .override_sw, .swing_cancel, .shutdown_min, .bk_rdata,
        .stop_out, .swing_pv_stop, .warn_code, .bk_re, .bk_we, .bk_addr, .bk_wdata);
    csup_bkmem csup_bkmem_inst (.hclk, .bk_re, .bk_we, .bk_addr, .bk_wdata, .bk_rdata);
    initial forever #50 hclk = ~hclk;
    task automatic chk(input string name, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one single AHB-Lite transfer, entered just after a clock edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic restart(input logic [15:0] mins);
        hresetn <= 1'b0;
        shutdown_min <= mins;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (30) @(posedge hclk);
    endtask
    // a value clear of the limit by more than the band
    function automatic logic [15:0] near(input logic [15:0] l);
        return $urandom_range(0, 1) ? l + 16'($urandom_range(3, 60)) : l - 16'($urandom_range(3, 60));
    endfunction
    // expected {swing stops, stops, code}, all limits enabled
    function automatic logic [31:0] model();
        int meas [6];
        logic [8:0] st;
        logic [15:0] code;
        logic want, canc;
        meas = '{height, boom_angle, boom_angle, radius, swing_angle, swing_angle};
        st = 9'h0;
        code = 16'h0;
        for (int i = 5; i >= 0; i--) begin
            want = (CSUP_LOWER_LIM[i] ? meas[i] <= lim[i] : meas[i] >= lim[i])
                   && (motion_cmd & CSUP_MASK_LIM[i]) != 9'h0 && (i < 4 || cfg[1]);
            canc = i < 4 ? override_sw : swing_cancel | (override_sw & !cfg[0]);
            if (want && !canc) st |= CSUP_MASK_LIM[i];
            if (want && (!canc || i > 3)) code = CSUP_W_LIM[i];
        end
        if (boom_angle > BSL) begin
            code = (motion_cmd & CSUP_MASK_BS) != 9'h0 ? 16'h0025 : 16'h0012;
            if (code == 16'h0025) st |= CSUP_MASK_BS;
        end
        return {7'h0, st, code};
    endfunction
    task automatic tally_and_finish();
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge hclk);
        failures++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(38));
        lim = '{16'h0100, 16'h7000, 16'h1000, 16'h0200, 16'h0300, 16'h0100};
        height <= lim[0];
        restart(16'h00C8);
        bus(1'b0, CSUP_OFS_BSLIM, 32'h0);
        chk("bslim reset", rd, {16'h0, CSUP_BSLIM_RST});
        bus(1'b0, CSUP_OFS_HYST, 32'h0);
        chk("hyst reset", rd, {16'h0, CSUP_HYST_RST});
        bus(1'b1, 8'hF0, 32'hFFFF);
        bus(1'b0, 8'hF0, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, CSUP_OFS_HYST, 32'h2);
        bus(1'b1, CSUP_OFS_BSLIM, {16'h0, BSL});
        for (int i = 1; i < 6; i++) bus(1'b1, CSUP_OFS_LIMIT0 + 8'(4 * i), {16'h0, lim[i]});
        bus(1'b1, CSUP_OFS_CTRL, 32'h1BF);
        bus(1'b0, CSUP_OFS_LIMIT0, 32'h0);
        chk("taught", rd, {16'h0, lim[0]});
        repeat (40) begin
            cfg = $urandom_range(0, 3);
            bus(1'b1, CSUP_OFS_CTRL, 32'h3F | 32'(cfg << 6));
            height <= near(lim[0]);
            radius <= near(lim[3]);
            boom_angle <= near(16'($urandom_range(1, 8) << 12));
            swing_angle <= near(16'($urandom_range(1, 3) << 8));
            override_sw <= 1'($urandom_range(0, 1));
            swing_cancel <= 1'($urandom_range(0, 1));
            @(posedge hclk); // flags settle before motion
            motion_cmd <= 9'($urandom_range(1, 511));
            repeat (4) @(posedge hclk);
            chk("stops", outs, model());
            motion_cmd <= 9'h0;
            repeat (HOLD + 6) @(posedge hclk);
        end
        override_sw <= 1'b1;
        swing_cancel <= 1'b0;
        boom_angle <= BSL + 16'h10;
        height <= 16'h0;
        radius <= 16'h0;
        swing_angle <= 16'h0200;
        motion_cmd <= 9'h004;
        repeat (3) @(posedge hclk);
        motion_cmd <= 9'h0;
        repeat (HOLD - 2) @(posedge hclk);
        chk("held", outs, 32'h00060025);
        repeat (6) @(posedge hclk);
        chk("released", outs, 32'h00000012);
        bus(1'b0, CSUP_OFS_STATUS, 32'h0);
        chk("status", rd, 32'h00420012);
        restart(16'h003C);
        bus(1'b0, CSUP_OFS_LIMIT0 + 8'h8, 32'h0);
        chk("restored limit", rd, {16'h0, lim[2]});
        bus(1'b0, CSUP_OFS_CTRL, 32'h0);
        chk("restored enables", rd, 32'h3F);
        restart(16'h0079);
        bus(1'b0, CSUP_OFS_CTRL, 32'h0);
        chk("late enables", rd, 32'h0);
        tally_and_finish();
    end
endmodule
